// [bench/dsoa_ovh_partner.sv]
// dsoa_ovh_partner: external overhead and stuff-bit logic on the transmit port.
// assumes output-mode sync; notes the bit it offers for each overhead slot.
`timescale 1ns/1ns
module dsoa_ovh_partner (
    // overhead port
    input  wire logic tx_overhead_clock,
    output logic      tx_overhead_data,
    output logic      tx_overhead_insert_enable,
    output logic      tx_overhead_sync_in,
    // stuff port
    input  wire logic tx_stuff_clock,
    output logic      tx_stuff_data
);
    logic [1:0] notes[$];

    task automatic offer();
        tx_overhead_data          = 1'($urandom);
        tx_overhead_insert_enable = 1'($urandom);
        notes.push_back({tx_overhead_insert_enable, tx_overhead_data});
    endtask : offer

    // sync held low, only meaningful in input mode
    initial begin
        tx_overhead_sync_in = 1'b0;
        tx_stuff_data       = 1'b0;
        offer();
    end

    // new bit right after the fall, held through the next slot
    always @(negedge tx_overhead_clock) offer();
    always @(negedge tx_stuff_clock) tx_stuff_data = 1'($urandom);
endmodule : dsoa_ovh_partner

// [bench/tb_top.sv]
// tb_top: self-checking bench for the overhead and stuff-bit access port.
// assumes one m-frame of traffic each way; rx and tx line clocks 125 ns, unrelated.
`timescale 1ns/1ns
module tb_top;
    import dsoa_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, rx_line_clock = 1'b0, tx_line_clock = 1'b0;
    logic rx_line_data = 1'b1, tx_line_data_in = 1'b0, rx_mframe_start = 1'b0;
    logic tx_mframe_start = 1'b0, rx_on = 1'b0, tx_on = 1'b0, m13 = 1'b0, ovr;
    dsoa_alarm_t framer_state = '0;
    logic tx_line_data_out, rx_red_alarm, rx_signal_loss, rx_frame_loss, rx_ais_alarm;
    logic tx_overhead_clock, tx_overhead_data, tx_overhead_insert_enable, tx_overhead_sync_in;
    logic tx_overhead_sync_out, tx_overhead_sync_oe_n, tx_stuff_clock, tx_stuff_data;
    logic rx_overhead_clock, rx_overhead_data, rx_overhead_sync, rx_stuff_clock, rx_stuff_data;
    logic [2:0] al_q[$];
    logic [1:0] rx_q[$];
    logic       st_q[$];
    logic [2:0] al_seen = 3'h0;
    logic [1:0] note;
    int mismatches = 0, total_checks = 0, ovh_n = 0, stf_n = 0;

    always #5 clock = ~clock;
    always begin #62 rx_line_clock = 1'b1; #63 rx_line_clock = 1'b0; end
    initial begin #37; forever begin #62 tx_line_clock = 1'b1; #63 tx_line_clock = 1'b0; end end
    always @(negedge tx_line_clock) tx_line_data_in = 1'($urandom);

    dsoa_access_port i_dsoa_access_port (.clock(clock), .reset_n(reset_n),
        .rx_line_clock(rx_line_clock), .rx_line_data(rx_line_data), .tx_line_clock(tx_line_clock),
        .framer_state(framer_state), .rx_mframe_start(rx_mframe_start),
        .tx_mframe_start(tx_mframe_start), .tx_line_data_in(tx_line_data_in),
        .tx_line_data_out(tx_line_data_out), .m13_async_mode(m13),
        .tx_stuff_insert_enable(1'b1), .tx_sync_is_output(1'b1), .rx_red_alarm(rx_red_alarm),
        .rx_signal_loss(rx_signal_loss), .rx_frame_loss(rx_frame_loss),
        .rx_ais_alarm(rx_ais_alarm), .tx_overhead_clock(tx_overhead_clock),
        .tx_overhead_data(tx_overhead_data), .tx_overhead_insert_enable(tx_overhead_insert_enable),
        .tx_overhead_sync_in(tx_overhead_sync_in), .tx_overhead_sync_out(tx_overhead_sync_out),
        .tx_overhead_sync_oe_n(tx_overhead_sync_oe_n), .tx_stuff_clock(tx_stuff_clock),
        .tx_stuff_data(tx_stuff_data), .rx_overhead_clock(rx_overhead_clock),
        .rx_overhead_data(rx_overhead_data), .rx_overhead_sync(rx_overhead_sync),
        .rx_overhead_overrun(ovr), .rx_stuff_clock(rx_stuff_clock), .rx_stuff_data(rx_stuff_data));

    dsoa_ovh_partner i_dsoa_ovh_partner (.tx_overhead_clock(tx_overhead_clock),
        .tx_overhead_data(tx_overhead_data), .tx_overhead_insert_enable(tx_overhead_insert_enable),
        .tx_overhead_sync_in(tx_overhead_sync_in), .tx_stuff_clock(tx_stuff_clock),
        .tx_stuff_data(tx_stuff_data));

    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    always @(posedge clock) begin
        #2;
        if ({rx_red_alarm, rx_frame_loss, rx_ais_alarm} !== al_seen) begin
            al_seen = {rx_red_alarm, rx_frame_loss, rx_ais_alarm};
            chk("alarms", (al_q.size() > 0) ? al_q.pop_front() : ~al_seen, al_seen);
        end
    end
    always @(posedge tx_overhead_clock) begin
        #1;
        note = i_dsoa_ovh_partner.notes.pop_front();
        if (tx_on) begin
            chk("tx_ovh_bit", note[1] ? note[0] : tx_line_data_in, tx_line_data_out);
            chk("tx_ovh_sync", 8'(ovh_n == 0), tx_overhead_sync_out);
            ovh_n++;
        end
    end
    always @(posedge tx_stuff_clock) begin
        #1;
        if (tx_on) begin
            chk("tx_stuff_bit", tx_stuff_data, tx_line_data_out);
            stf_n++;
        end
    end
    always @(posedge rx_overhead_clock) #1 if (rx_on)
        chk("rx_ovh", (rx_q.size() > 0) ? rx_q.pop_front() : 8'hFF, {rx_overhead_data, rx_overhead_sync});
    always @(negedge rx_stuff_clock) if (rx_on)
        chk("rx_stuff", (st_q.size() > 0) ? st_q.pop_front() : 8'hFF, rx_stuff_data);
    always @(posedge ovr) chk("overrun", 8'h0, 8'h1);

    task automatic los_step(logic d, logic exp);
        @(negedge rx_line_clock) rx_line_data = d;
        @(posedge rx_line_clock);
        repeat (6) @(posedge clock);
        chk("signal_loss", exp, rx_signal_loss);
    endtask : los_step

    initial begin
        void'($urandom(32'h3CC14315));
        repeat (4) @(posedge clock);
        #1 reset_n = 1'b1;
        for (int i = 1; i <= 8; i++) begin
            @(posedge clock);
            #1 framer_state = 3'(i);
            al_q.push_back(3'(i));
            repeat (3) @(posedge clock);
        end
        $display("alarm test done");
        repeat (173) @(negedge rx_line_clock) rx_line_data = 1'b0;
        los_step(1'b0, 1'b0);
        los_step(1'b0, 1'b1);
        los_step(1'b1, 1'b0);
        $display("signal loss test done");
        #1 m13 = 1'b1;
        fork
            begin
                @(posedge rx_line_clock);
                repeat (3) @(posedge clock);
                #1 rx_mframe_start = 1'b1;
                @(posedge clock);
                #1 rx_mframe_start = 1'b0;
                for (int k = 0; k < 4762; k++) begin
                    @(negedge rx_line_clock);
                    rx_line_data = 1'($urandom);
                    rx_on = (k > 0);
                    if (k % 85 == 0 && k <= 4760) rx_q.push_back({rx_line_data, k % 4760 == 0});
                    if (k < 4760 && (k % 680) / 85 == 7 && k % 85 == k / 680 + 1)
                        st_q.push_back(rx_line_data);
                end
            end
            begin
                @(posedge tx_line_clock);
                repeat (3) @(posedge clock);
                #1 tx_mframe_start = 1'b1;
                @(posedge clock);
                #1 tx_mframe_start = 1'b0;
                @(posedge clock);
                #1 tx_on = 1'b1;
                repeat (4760) @(posedge tx_line_clock);
                tx_on = 1'b0;
                chk("ovh_pulses", 8'd56, 8'(ovh_n));
                chk("stuff_pulses", 8'd7, 8'(stf_n));
                chk("sync_oe_n", 8'h00, tx_overhead_sync_oe_n);
            end
        join
        repeat (3) @(posedge rx_line_clock);
        repeat (6) @(posedge clock);
        chk("rx_left", 8'h00, 8'(rx_q.size() + st_q.size()));
        $display("frame test done");
        final_report();
    end

    initial begin
        #800000;
        mismatches++;
        $display("[ERR] watchdog expected end seen hang");
        final_report();
    end
endmodule : tb_top

// [hw/dsoa_access_port.sv]
// dsoa_access_port: ds3 alarm outputs and serial overhead / stuff-bit access ports.
// assumes line clocks and access pins are asynchronous pins; framer signals share clock.
// Overview of operation
// R1: red alarm output follows framer red state
// R2: signal loss after 175 consecutive zero bits
// R3: frame loss output follows framer lof state
// R4: ais output follows framer ais state
// R5: transmit overhead clock, about 526 kHz nominal
// R6: sample overhead data, insert only enabled bits
// R7: external logic presents enable with its data
// R8: output-mode sync marks first-subframe x-bit slot
// R9: input-mode sync comes with the x1 bit
// R10: stuff clock out, stuff data sampled on rise
// R11: stuff insertion only in m13 asynchronous format
// R12: receive overhead clock, 526 kHz nominal
// R13: extracted overhead bits serially, on clock rise
// R14: receive sync marks exactly the x1 bit
// R15: receive stuff data only in m13 format
// R16: overhead clocks gapped, one pulse per slot
// R17: stuff clocks pulse per opportunity, m13 only
`timescale 1ns/1ns
module dsoa_access_port (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    // ds3 line pins
    input  wire logic                 rx_line_clock,
    input  wire logic                 rx_line_data,
    input  wire logic                 tx_line_clock,
    // framer and multiplexer side
    input  wire dsoa_pkg::dsoa_alarm_t framer_state,
    input  wire logic                 rx_mframe_start,
    input  wire logic                 tx_mframe_start,
    input  wire logic                 tx_line_data_in,
    output logic                      tx_line_data_out,
    // configuration
    input  wire logic                 m13_async_mode,
    input  wire logic                 tx_stuff_insert_enable,
    input  wire logic                 tx_sync_is_output,
    // alarm outputs
    output logic                      rx_red_alarm,
    output logic                      rx_signal_loss,
    output logic                      rx_frame_loss,
    output logic                      rx_ais_alarm,
    // transmit overhead port
    output logic                      tx_overhead_clock,
    input  wire logic                 tx_overhead_data,
    input  wire logic                 tx_overhead_insert_enable,
    input  wire logic                 tx_overhead_sync_in,
    output logic                      tx_overhead_sync_out,
    output logic                      tx_overhead_sync_oe_n,
    // transmit stuff port
    output logic                      tx_stuff_clock,
    input  wire logic                 tx_stuff_data,
    // receive overhead and stuff ports
    output logic                      rx_overhead_clock,
    output logic                      rx_overhead_data,
    output logic                      rx_overhead_sync,
    output logic                      rx_overhead_overrun,
    output logic                      rx_stuff_clock,
    output logic                      rx_stuff_data
);
    import dsoa_pkg::*;

    function automatic logic is_ovh_slot(input dsoa_pos_t p);
        return p.bitn == DSOA_OVH_BIT;
    endfunction : is_ovh_slot

    function automatic logic is_x1_slot(input dsoa_pos_t p);
        return is_ovh_slot(p) && (p.sub == 3'h0) && (p.blk == 3'h0);
    endfunction : is_x1_slot

    // stuff bit of tributary n is its first bit in the last block of subframe n
    function automatic logic is_stuff_slot(input dsoa_pos_t p);
        return (p.blk == DSOA_STUFF_BLOCK) && (p.bitn == {4'h0, p.sub} + 7'h01);
    endfunction : is_stuff_slot

    // pin synchronisers: stage one is read only by stage two
    logic [DSOA_PIN_COUNT-1:0] pin_meta_r, pin_sync_r, pin_sync_nxt;
    logic                      rx_clk_prev_r, tx_clk_prev_r;
    logic                      rx_edge, tx_edge;
    logic                      rx_bit, ovh_d, ovh_en, ovh_sync, stuff_d;

    always_comb begin
        pin_sync_nxt = pin_meta_r;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_r    <= '0;
            pin_sync_r    <= '0;
            rx_clk_prev_r <= 1'b0;
            tx_clk_prev_r <= 1'b0;
        end else begin
            pin_meta_r    <= {tx_stuff_data, tx_overhead_sync_in, tx_overhead_insert_enable,
                              tx_overhead_data, tx_line_clock, rx_line_data, rx_line_clock};
            pin_sync_r    <= pin_sync_nxt;
            rx_clk_prev_r <= pin_sync_r[DSOA_PIN_RX_CLK];
            tx_clk_prev_r <= pin_sync_r[DSOA_PIN_TX_CLK];
        end
    end

    assign rx_edge  = pin_sync_r[DSOA_PIN_RX_CLK] && !rx_clk_prev_r;
    assign tx_edge  = pin_sync_r[DSOA_PIN_TX_CLK] && !tx_clk_prev_r;
    assign rx_bit   = pin_sync_r[DSOA_PIN_RX_DATA];
    assign ovh_d    = pin_sync_r[DSOA_PIN_OVH_DATA];
    assign ovh_en   = pin_sync_r[DSOA_PIN_OVH_EN];
    assign ovh_sync = pin_sync_r[DSOA_PIN_OVH_SYNC];
    assign stuff_d  = pin_sync_r[DSOA_PIN_STUFF_DATA];

    // frame positions of both directions
    dsoa_pos_t rx_pos, tx_pos;
    logic      tx_resync;

    dsoa_frame_counter u_rx_pos (
        .clock    (clock),
        .reset_n  (reset_n),
        .step     (rx_edge),
        .load     (rx_mframe_start),
        .load_val (DSOA_POS_RESET),
        .pos      (rx_pos)
    );

    // R9 realign to an external x1 marker
    assign tx_resync = !tx_sync_is_output && tx_edge && is_ovh_slot(tx_pos) && ovh_sync;

    dsoa_frame_counter u_tx_pos (
        .clock    (clock),
        .reset_n  (reset_n),
        .step     (tx_edge),
        .load     (tx_mframe_start || tx_resync),
        .load_val (tx_mframe_start ? DSOA_POS_RESET : DSOA_POS_AFTER_X1),
        .pos      (tx_pos)
    );

    // receive overhead bits queue here so a late output slot loses nothing
    dsoa_ovh_t buf_in, buf_out;
    logic      buf_in_valid, buf_in_ready, buf_out_valid;

    assign buf_in_valid = rx_edge && is_ovh_slot(rx_pos);
    assign buf_in       = '{data: rx_bit, sync: is_x1_slot(rx_pos)};

    dsoa_buffer #(
        .WIDTH ($bits(dsoa_ovh_t)),
        .DEPTH (DSOA_RX_BUF_DEPTH)
    ) u_rx_buf (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in),
        .out_valid (buf_out_valid),
        .out_ready (rx_edge),
        .out_data  (buf_out)
    );

    // receive side state
    dsoa_alarm_t alarm_r, alarm_nxt;
    logic [7:0]  zero_cnt_r, zero_cnt_nxt;
    logic        rx_ovh_clk_r, rx_ovh_clk_nxt, rx_ovh_d_r, rx_ovh_d_nxt;
    logic        rx_ovh_sync_r, rx_ovh_sync_nxt, overrun_r, overrun_nxt;
    logic        rx_stf_clk_r, rx_stf_clk_nxt, rx_stf_d_r, rx_stf_d_nxt;

    always_comb begin
        // R1 R3 R4 alarms mirror the framer
        alarm_nxt       = framer_state;
        zero_cnt_nxt    = zero_cnt_r;
        rx_ovh_clk_nxt  = rx_ovh_clk_r;
        rx_ovh_d_nxt    = rx_ovh_d_r;
        rx_ovh_sync_nxt = rx_ovh_sync_r;
        rx_stf_clk_nxt  = rx_stf_clk_r;
        rx_stf_d_nxt    = rx_stf_d_r;
        overrun_nxt     = buf_in_valid && !buf_in_ready;
        if (rx_edge) begin
            // R2 saturating run of zeros, any one restarts it
            if (rx_bit) begin
                zero_cnt_nxt = 8'h00;
            end else if (zero_cnt_r != DSOA_LOS_ZEROS) begin
                zero_cnt_nxt = zero_cnt_r + 8'h01;
            end
            // R12 R16 clock high for one line bit, data changes with its rise
            rx_ovh_clk_nxt = buf_out_valid;
            rx_ovh_sync_nxt = buf_out_valid && buf_out.sync;
            if (buf_out_valid) begin
                // R13 R14 data and x1 marker leave together
                rx_ovh_d_nxt    = buf_out.data;
            end
            // R15 R17 stuff port only runs in m13 asynchronous format
            rx_stf_clk_nxt = m13_async_mode && is_stuff_slot(rx_pos);
            if (rx_stf_clk_nxt) begin
                rx_stf_d_nxt = rx_bit;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            alarm_r       <= '0;
            zero_cnt_r    <= 8'h00;
            rx_ovh_clk_r  <= 1'b0;
            rx_ovh_d_r    <= 1'b0;
            rx_ovh_sync_r <= 1'b0;
            rx_stf_clk_r  <= 1'b0;
            rx_stf_d_r    <= 1'b0;
            overrun_r     <= 1'b0;
        end else begin
            alarm_r       <= alarm_nxt;
            zero_cnt_r    <= zero_cnt_nxt;
            rx_ovh_clk_r  <= rx_ovh_clk_nxt;
            rx_ovh_d_r    <= rx_ovh_d_nxt;
            rx_ovh_sync_r <= rx_ovh_sync_nxt;
            rx_stf_clk_r  <= rx_stf_clk_nxt;
            rx_stf_d_r    <= rx_stf_d_nxt;
            overrun_r     <= overrun_nxt;
        end
    end

    // transmit side state
    logic tx_ovh_clk_r, tx_ovh_clk_nxt, tx_sync_r, tx_sync_nxt, oe_n_r, oe_n_nxt;
    logic tx_stf_clk_r, tx_stf_clk_nxt, tx_out_r, tx_out_nxt;

    always_comb begin
        tx_ovh_clk_nxt = tx_ovh_clk_r;
        tx_sync_nxt    = tx_sync_r;
        tx_stf_clk_nxt = tx_stf_clk_r;
        tx_out_nxt     = tx_out_r;
        oe_n_nxt       = !tx_sync_is_output;
        if (tx_edge) begin
            tx_out_nxt = tx_line_data_in;
            // R5 R16 one gapped pulse per overhead slot
            tx_ovh_clk_nxt = is_ovh_slot(tx_pos);
            // R8 marker rises with the clock on the x1 slot
            tx_sync_nxt = tx_sync_is_output && is_x1_slot(tx_pos);
            // R10 R17 stuff clock only in m13 asynchronous format
            tx_stf_clk_nxt = m13_async_mode && is_stuff_slot(tx_pos);
            // R6 R7 data and enable are taken at the same rise
            if (is_ovh_slot(tx_pos) && ovh_en) begin
                tx_out_nxt = ovh_d;
            end
            // R11 stuffed bit replaced only when selected
            if (tx_stf_clk_nxt && tx_stuff_insert_enable) begin
                tx_out_nxt = stuff_d;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_ovh_clk_r <= 1'b0;
            tx_sync_r    <= 1'b0;
            tx_stf_clk_r <= 1'b0;
            tx_out_r     <= 1'b0;
            oe_n_r       <= 1'b1;
        end else begin
            tx_ovh_clk_r <= tx_ovh_clk_nxt;
            tx_sync_r    <= tx_sync_nxt;
            tx_stf_clk_r <= tx_stf_clk_nxt;
            tx_out_r     <= tx_out_nxt;
            oe_n_r       <= oe_n_nxt;
        end
    end

    assign rx_red_alarm          = alarm_r.red;
    assign rx_frame_loss         = alarm_r.lof;
    assign rx_ais_alarm          = alarm_r.ais;
    assign rx_signal_loss        = (zero_cnt_r == DSOA_LOS_ZEROS);
    assign rx_overhead_clock     = rx_ovh_clk_r;
    assign rx_overhead_data      = rx_ovh_d_r;
    assign rx_overhead_sync      = rx_ovh_sync_r;
    assign rx_overhead_overrun   = overrun_r;
    assign rx_stuff_clock        = rx_stf_clk_r;
    assign rx_stuff_data         = rx_stf_d_r;
    assign tx_overhead_clock     = tx_ovh_clk_r;
    assign tx_overhead_sync_out  = tx_sync_r;
    assign tx_overhead_sync_oe_n = oe_n_r;
    assign tx_stuff_clock        = tx_stf_clk_r;
    assign tx_line_data_out      = tx_out_r;

    // checks
    property p_red;
        @(posedge clock) disable iff (!reset_n) framer_state.red |=> rx_red_alarm;
    endproperty
    a_red: assert property (p_red) else $error("red alarm not following framer"); // R1
    property p_los_clear;
        @(posedge clock) disable iff (!reset_n) (rx_edge && rx_bit) |=> !rx_signal_loss;
    endproperty
    a_los_clear: assert property (p_los_clear) else $error("signal loss held after a one"); // R2
    property p_los_set;
        @(posedge clock) disable iff (!reset_n)
            (rx_edge && !rx_bit && zero_cnt_r == 8'hAE) |=> rx_signal_loss;
    endproperty
    a_los_set: assert property (p_los_set) else $error("signal loss late"); // R2
    property p_lof_ais;
        @(posedge clock) disable iff (!reset_n)
            ##1 (rx_frame_loss == $past(framer_state.lof)) && (rx_ais_alarm == $past(framer_state.ais));
    endproperty
    a_lof_ais: assert property (p_lof_ais) else $error("lof or ais mismatch"); // R3 R4
    property p_tx_clk_slot;
        @(posedge clock) disable iff (!reset_n)
            $rose(tx_overhead_clock) |-> $past(tx_edge) && $past(tx_pos.bitn) == 7'h00;
    endproperty
    a_tx_clk_slot: assert property (p_tx_clk_slot) else $error("overhead clock off slot"); // R16
    property p_insert;
        @(posedge clock) disable iff (!reset_n)
            (tx_edge && is_ovh_slot(tx_pos) && ovh_en) |=> tx_line_data_out == $past(ovh_d);
    endproperty
    a_insert: assert property (p_insert) else $error("enabled overhead bit not inserted"); // R6
    property p_no_insert;
        @(posedge clock) disable iff (!reset_n)
            (tx_edge && !ovh_en && !is_stuff_slot(tx_pos)) |=> tx_line_data_out == $past(tx_line_data_in);
    endproperty
    a_no_insert: assert property (p_no_insert) else $error("bit altered without enable"); // R6
    property p_tx_sync;
        @(posedge clock) disable iff (!reset_n) tx_overhead_sync_out |-> tx_overhead_clock;
    endproperty
    a_tx_sync: assert property (p_tx_sync) else $error("sync outside overhead clock"); // R8
    property p_stuff_mode;
        @(posedge clock) disable iff (!reset_n)
            $rose(tx_stuff_clock) || $rose(rx_stuff_clock) |-> $past(m13_async_mode);
    endproperty
    a_stuff_mode: assert property (p_stuff_mode) else $error("stuff clock outside m13"); // R17

    property p_rx_sync;
        @(posedge clock) disable iff (!reset_n) rx_overhead_sync |-> rx_overhead_clock ##1 1'b1;
    endproperty
    a_rx_sync: assert property (p_rx_sync) else $error("rx sync outside overhead clock"); // R14

    property p_rx_data;
        @(posedge clock) disable iff (!reset_n)
            (rx_edge && buf_out_valid) |=> rx_overhead_clock && rx_overhead_data == $past(buf_out.data);
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("rx overhead data wrong"); // R13

    c_los:     cover property (@(posedge clock) disable iff (!reset_n) $rose(rx_signal_loss));
    c_insert:  cover property (@(posedge clock) disable iff (!reset_n) tx_edge && ovh_en && is_ovh_slot(tx_pos));
    c_rx_sync: cover property (@(posedge clock) disable iff (!reset_n) $rose(rx_overhead_sync));
    c_stuff:   cover property (@(posedge clock) disable iff (!reset_n) $rose(rx_stuff_clock));

endmodule : dsoa_access_port

// [hw/dsoa_buffer.sv]
// dsoa_buffer: small fifo with valid/ready on both sides.
// assumes the drain may stall; in_ready drops honestly once all entries are taken.
`timescale 1ns/1ns
module dsoa_buffer #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    import dsoa_pkg::*;

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r   [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : bump

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        wr_nxt  = push ? bump(wr_r) : wr_r;
        rd_nxt  = pop ? bump(rd_r) : rd_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        if (push) begin
            mem_nxt[wr_r] = in_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule : dsoa_buffer

// [hw/dsoa_frame_counter.sv]
// dsoa_frame_counter: tracks the ds3 m-frame bit position of a line direction.
// assumes step is a one-cycle pulse per line bit; load wins over step.
`timescale 1ns/1ns
module dsoa_frame_counter (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               reset_n,
    // control
    input  wire logic               step,
    input  wire logic               load,
    input  wire dsoa_pkg::dsoa_pos_t load_val,
    // position of the next bit
    output dsoa_pkg::dsoa_pos_t     pos
);
    import dsoa_pkg::*;

    dsoa_pos_t pos_r;
    dsoa_pos_t pos_nxt;

    always_comb begin
        pos_nxt = pos_r;
        if (load) begin
            pos_nxt = load_val;
        end else if (step) begin
            if (pos_r.bitn == 7'(DSOA_BITS_PER_BLOCK - 1)) begin
                pos_nxt.bitn = 7'h00;
                if (pos_r.blk == 3'(DSOA_BLOCKS_PER_SUB - 1)) begin
                    pos_nxt.blk = 3'h0;
                    pos_nxt.sub = (pos_r.sub == 3'(DSOA_SUBFRAMES - 1)) ? 3'h0 : pos_r.sub + 3'h1;
                end else begin
                    pos_nxt.blk = pos_r.blk + 3'h1;
                end
            end else begin
                pos_nxt.bitn = pos_r.bitn + 7'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pos_r <= DSOA_POS_RESET;
        end else begin
            pos_r <= pos_nxt;
        end
    end

    assign pos = pos_r;

endmodule : dsoa_frame_counter

// [hw/dsoa_pkg.sv]
// dsoa_pkg: constants and carrier types for the ds3 overhead and stuff-bit access port.
// assumes a 100 MHz system clock and a ds3 line clock far slower than it.
package dsoa_pkg;

    // ds3 m-frame geometry: 7 subframes of 8 blocks, each 1 overhead bit plus 84 payload bits
    localparam int unsigned DSOA_BITS_PER_BLOCK = 85;
    localparam int unsigned DSOA_BLOCKS_PER_SUB = 8;
    localparam int unsigned DSOA_SUBFRAMES      = 7;
    // the block that carries the stuff opportunities, counted from 0
    localparam logic [2:0]  DSOA_STUFF_BLOCK    = 3'h7;
    // overhead bit sits first in each block
    localparam logic [6:0]  DSOA_OVH_BIT        = 7'h00;

    // nominal rates; the overhead clock is the line rate over one block length
    localparam int unsigned DSOA_LINE_RATE_HZ   = 44736000;
    localparam int unsigned DSOA_OVH_RATE_HZ    = DSOA_LINE_RATE_HZ / DSOA_BITS_PER_BLOCK;

    // consecutive zeros that declare loss of signal
    localparam logic [7:0]  DSOA_LOS_ZEROS      = 8'hAF;

    // pin synchroniser slots
    localparam int unsigned DSOA_PIN_RX_CLK     = 0;
    localparam int unsigned DSOA_PIN_RX_DATA    = 1;
    localparam int unsigned DSOA_PIN_TX_CLK     = 2;
    localparam int unsigned DSOA_PIN_OVH_DATA   = 3;
    localparam int unsigned DSOA_PIN_OVH_EN     = 4;
    localparam int unsigned DSOA_PIN_OVH_SYNC   = 5;
    localparam int unsigned DSOA_PIN_STUFF_DATA = 6;
    localparam int unsigned DSOA_PIN_COUNT      = 7;

    // two-entry buffer in the receive overhead path
    localparam int unsigned DSOA_RX_BUF_DEPTH   = 2;

    // position of the bit at the next line clock edge
    typedef struct packed {
        logic [2:0] sub;
        logic [2:0] blk;
        logic [6:0] bitn;
    } dsoa_pos_t;

    localparam dsoa_pos_t DSOA_POS_RESET  = '{sub: 3'h0, blk: 3'h0, bitn: 7'h00};
    // slot after the first-subframe x-bit, used when realigning to an external sync
    localparam dsoa_pos_t DSOA_POS_AFTER_X1 = '{sub: 3'h0, blk: 3'h0, bitn: 7'h01};

    // receive framer states reported on the alarm outputs
    typedef struct packed {
        logic red;
        logic lof;
        logic ais;
    } dsoa_alarm_t;

    // one extracted receive overhead bit and its x1 marker
    typedef struct packed {
        logic data;
        logic sync;
    } dsoa_ovh_t;

endpackage : dsoa_pkg
